/* core/scd_pkg.sv */
// Shared constants for the serdes parallel codec port
package scd_pkg;
   localparam int WORD_W = 10;
   localparam int BYTE_W = 8;
   localparam int TX_K_BIT = 8;
   localparam int RX_K_BIT = 8;
   localparam int RX_LCV_BIT = 9;
   localparam int BAL6 = 3;
   localparam int BAL4 = 2;
   localparam int COMMA_W = 7;
   localparam int OFF_W = 4;
   localparam logic [4:0] WIN_TOP = 5'h13;
   localparam logic [6:0] COMMA_POS = 7'h1F;
   localparam logic [6:0] COMMA_NEG = 7'h60;
   localparam logic [4:0] K28_X = 5'h1C;
   localparam logic [2:0] Y7 = 3'h7;
   localparam logic [5:0] K28_6B = 6'h0F;
   localparam logic [5:0] D7_6B = 6'h38;
   localparam logic [3:0] D3_4B = 4'hC;
   localparam logic [3:0] A7_4B = 4'h7;
   typedef enum logic {
      SCD_RX_WRITE = 1'b0,
      SCD_RX_READ = 1'b1
   } scd_rxmode_e;
endpackage : scd_pkg

/* core/scd_code_if.sv */
// Carrier between port logic and the 8b/10b codec
`timescale 1ns/1ns
`default_nettype none
interface scd_code_if;
   logic tx_go;
   logic [scd_pkg::BYTE_W-1:0] tx_byte;
   logic tx_k;
   logic [scd_pkg::WORD_W-1:0] tx_code;
   logic rx_go;
   logic [scd_pkg::WORD_W-1:0] rx_code;
   logic [scd_pkg::BYTE_W-1:0] rx_byte;
   logic rx_k;
   logic rx_viol;
   modport port (output tx_go, tx_byte, tx_k, rx_go, rx_code,
                 input tx_code, rx_byte, rx_k, rx_viol);
   modport codec (input tx_go, tx_byte, tx_k, rx_go, rx_code,
                  output tx_code, rx_byte, rx_k, rx_viol);
endinterface : scd_code_if
`default_nettype wire

/* core/scd_codec.sv */
// 8b/10b encoder and decoder with running disparity
`timescale 1ns/1ns
`default_nettype none
module scd_codec (
   input wire logic core_clk,
   input wire logic rst,
   scd_code_if.codec cif
);
   // RD- column; code bit order a..i then f..j, a in the top bit
   localparam logic [5:0] T6 [32] = '{
      6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
      6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
      6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
      6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
   localparam logic [3:0] T4 [8] = '{
      4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

   function automatic logic [5:0] pol6(input logic [5:0] v, input logic rd);
      logic flip;
      flip = ($countones(v) != scd_pkg::BAL6) || (v == scd_pkg::D7_6B);
      return (rd && flip) ? ~v : v;
   endfunction : pol6

   function automatic logic [3:0] pol4(input logic [3:0] v, input logic rd);
      logic flip;
      flip = ($countones(v) != scd_pkg::BAL4) || (v == scd_pkg::D3_4B);
      return (rd && flip) ? ~v : v;
   endfunction : pol4

   logic rd_tx_r;
   logic rd_rx_r;
   logic [4:0] ex;
   logic [2:0] ey;
   logic [5:0] e6;
   logic [3:0] e4;
   logic rd_e6;
   logic rd_e4;
   logic a7;
   assign ex = cif.tx_byte[4:0];
   assign ey = cif.tx_byte[7:5];
   logic k28_tx;
   logic [3:0] sel4;
   assign k28_tx = cif.tx_k && (ex == scd_pkg::K28_X);
   assign e6 = pol6(k28_tx ? scd_pkg::K28_6B : T6[ex], rd_tx_r);
   assign rd_e6 = rd_tx_r ^ ($countones(e6) != scd_pkg::BAL6);
   // Alternate y7 avoids a run of five equal bits
   assign a7 = (ey == scd_pkg::Y7) && (cif.tx_k
      || (!rd_e6 && (ex inside {5'h11, 5'h12, 5'h14}))
      || (rd_e6 && (ex inside {5'h0B, 5'h0D, 5'h0E})));
   assign sel4 = a7 ? scd_pkg::A7_4B : T4[ey];
   // K28 tail is the positive column, inverted whole when starting positive
   assign e4 = k28_tx ? (pol4(sel4, 1'b1) ^ {4{rd_tx_r}}) : pol4(sel4, rd_e6);
   assign rd_e4 = rd_e6 ^ ($countones(e4) != scd_pkg::BAL4);
   assign cif.tx_code = {e6, e4};

   logic [5:0] s6;
   logic [3:0] s4;
   logic [3:0] s4_line;
   logic flip4;
   logic [4:0] dx;
   logic [2:0] dy;
   logic hit6, ok6, hit4, ok4, k28, da7, rd_d6, rd_d4;
   assign s6 = cif.rx_code[9:4];
   assign s4_line = cif.rx_code[3:0];
   // Balanced K28 tails come inverted after the negative (110000) comma half
   assign flip4 = (s6 == ~scd_pkg::K28_6B) && ($countones(s4_line) == scd_pkg::BAL4)
      && (s4_line != scd_pkg::D3_4B) && (s4_line != ~scd_pkg::D3_4B);
   assign s4 = flip4 ? ~s4_line : s4_line;

   always_comb begin
      dx = '0;
      dy = '0;
      hit6 = 1'b0;
      ok6 = 1'b0;
      hit4 = 1'b0;
      ok4 = 1'b0;
      da7 = 1'b0;
      for (int i = 0; i < 32; i++) begin
         if (s6 == pol6(T6[i], 1'b0) || s6 == pol6(T6[i], 1'b1)) begin
            dx = 5'(i);
            hit6 = 1'b1;
            ok6 = (s6 == pol6(T6[i], rd_rx_r));
         end
      end
      k28 = (s6 == scd_pkg::K28_6B) || (s6 == ~scd_pkg::K28_6B);
      if (k28) begin
         dx = scd_pkg::K28_X;
         hit6 = 1'b1;
         ok6 = (s6 == pol6(scd_pkg::K28_6B, rd_rx_r));
      end
      if ($countones(s6) > scd_pkg::BAL6) rd_d6 = 1'b1;
      else if ($countones(s6) < scd_pkg::BAL6) rd_d6 = 1'b0;
      else rd_d6 = rd_rx_r;
      for (int j = 0; j < 8; j++) begin
         if (s4 == pol4(T4[j], 1'b0) || s4 == pol4(T4[j], 1'b1)) begin
            dy = 3'(j);
            hit4 = 1'b1;
            ok4 = (s4 == pol4(T4[j], rd_d6));
         end
      end
      if (s4 == scd_pkg::A7_4B || s4 == ~scd_pkg::A7_4B) begin
         dy = scd_pkg::Y7;
         da7 = 1'b1;
         hit4 = 1'b1;
         ok4 = (s4 == pol4(scd_pkg::A7_4B, rd_d6));
      end
      if ($countones(s4) > scd_pkg::BAL4) rd_d4 = 1'b1;
      else if ($countones(s4) < scd_pkg::BAL4) rd_d4 = 1'b0;
      else rd_d4 = rd_d6;
   end

   assign cif.rx_byte = {dy, dx};
   assign cif.rx_k = k28 || (da7 && (dx inside {5'h17, 5'h1B, 5'h1D, 5'h1E}));
   // Unknown group or wrong disparity
   assign cif.rx_viol = !(hit6 && ok6 && hit4 && ok4);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rd_tx_r <= 1'b0;
         rd_rx_r <= 1'b0;
      end else begin
         if (cif.tx_go) rd_tx_r <= rd_e4;
         if (cif.rx_go) rd_rx_r <= rd_d4;
      end
   end
endmodule : scd_codec
`default_nettype wire

/* core/scd_port.sv */
// Parallel-side port: tx word capture, rx word delivery, line status
`timescale 1ns/1ns
`default_nettype none
// Operation
// (R1) 10-bit mode: transmit word goes out unencoded, bit 9 first
// (R2) 8-bit mode: transmit bits 7..0 pass through the 8b/10b encoder
// (R3) 8-bit mode: transmit bit 8 picks control versus data group
// (R4) Transmit bit 8 is ordinary data in 10-bit mode
// (R5) Host holds transmit bit 9 low in 8-bit mode
// (R6) 10-bit mode: receive word is the raw aligned code-group
// (R7) 8-bit mode: receive bits 7..0 carry the decoded byte
// (R8) 8-bit mode: receive bit 8 high for control groups
// (R9) 8-bit mode: receive bit 9 pulses one output cycle per violation
// (R10) Host keeps transmit clock frequency-locked to the reference
// (R11) Write mode: receive clock pin drives the recovered clock
// (R12) Read mode: receive clock is input, word updates on both edges
// (R13) Host supplies read clock locked to incoming data rate
// (R14) System clock output runs only while mode select is low
// (R15) Loss of signal reported only in 8-bit mode
// (R16) Lock status output is low while the receive PLL is locked
// (R17) Comma flag needs lock; alignment snaps to comma when enabled
// (R18) One mode input sets 8-bit or 10-bit for both paths
// (R19) Transmit word sampled once per transmit clock, then held
module scd_port (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic word_mode_8b,
   input wire logic rx_clock_read_mode,
   input wire logic comma_align_enable,
   input wire logic operating_mode_select,
   input wire logic tx_parallel_clock,
   input wire logic [scd_pkg::WORD_W-1:0] tx_word,
   output logic [scd_pkg::WORD_W-1:0] tx_code_group,
   output logic tx_group_valid,
   input wire logic [scd_pkg::WORD_W-1:0] rx_code_group,
   input wire logic rx_group_valid,
   input wire logic rx_parallel_clock_i,
   output logic rx_parallel_clock_o,
   output logic rx_parallel_clock_oe_n,
   output logic [scd_pkg::WORD_W-1:0] rx_parallel_word,
   input wire logic system_clock_src,
   output logic system_clock_out,
   input wire logic signal_detect,
   output logic loss_of_signal,
   input wire logic rx_pll_locked,
   output logic rx_pll_unlocked_n,
   output logic comma_found
);
   localparam int PIN_W = scd_pkg::WORD_W + 5;
   localparam int W = scd_pkg::WORD_W;

   scd_code_if cif ();
   scd_codec u_codec (
      .core_clk(core_clk),
      .rst(rst),
      .cif(cif)
   );

   // Pin inputs cross into core_clk through two flops
   logic [PIN_W-1:0] pin_s1_r;
   logic [PIN_W-1:0] pin_s2_r;
   logic txc_s, rxc_s, lock_s, sig_s, opm_s;
   logic [W-1:0] txw_s;
   assign {txc_s, rxc_s, lock_s, sig_s, opm_s, txw_s} = pin_s2_r;

   logic txc_d_r, rxc_d_r;
   logic tx_edge, rx_edge;
   assign tx_edge = txc_s & ~txc_d_r;
   assign rx_edge = rxc_s ^ rxc_d_r;

   // Transmit path
   logic [W-1:0] tx_code_r, tx_code_nxt;
   logic tx_valid_r;
   assign cif.tx_go = tx_edge & word_mode_8b; // R18
   assign cif.tx_byte = txw_s[scd_pkg::BYTE_W-1:0]; // R2
   assign cif.tx_k = txw_s[scd_pkg::TX_K_BIT]; // R3
   // Bit 9 is assumed low from the host in 8-bit mode and is dropped
   assign tx_code_nxt = word_mode_8b ? cif.tx_code : txw_s; // R1 R4 R5

   // Comma search over two consecutive groups
   logic [W-1:0] prev_r;
   logic [2*W-1:0] win;
   logic [W-1:0] hit;
   logic [scd_pkg::OFF_W-1:0] off_r, first_off, cur_off;
   logic [W-1:0] grp;
   assign win = {prev_r, rx_code_group};
   for (genvar o = 0; o < W; o++) begin : g_comma
      assign hit[o] = (win[2*W-1-o -: scd_pkg::COMMA_W] == scd_pkg::COMMA_POS)
                   || (win[2*W-1-o -: scd_pkg::COMMA_W] == scd_pkg::COMMA_NEG);
   end

   function automatic logic [scd_pkg::OFF_W-1:0] lowest(input logic [W-1:0] h);
      logic [scd_pkg::OFF_W-1:0] f;
      f = '0;
      for (int i = W - 1; i >= 0; i--) begin
         if (h[i]) f = scd_pkg::OFF_W'(i);
      end
      return f;
   endfunction : lowest

   assign first_off = lowest(hit);
   assign cur_off = (comma_align_enable && |hit) ? first_off : off_r; // R17
   assign grp = win[scd_pkg::WIN_TOP - {1'b0, cur_off} -: W];

   // Receive path
   logic [W-1:0] rx_word_nxt, rx_pend_r, rx_word_r, rx_src;
   logic rx_upd, rx_clk_o_r, read_mode;
   assign read_mode = (rx_clock_read_mode == scd_pkg::SCD_RX_READ);
   assign cif.rx_go = rx_group_valid & word_mode_8b; // R18
   assign cif.rx_code = grp;
   assign rx_word_nxt = word_mode_8b
      ? {cif.rx_viol, cif.rx_k, cif.rx_byte} // R7 R8 R9
      : grp; // R6
   assign rx_upd = read_mode ? rx_edge : rx_group_valid; // R11 R12
   assign rx_src = read_mode ? rx_pend_r : rx_word_nxt;

   logic los_r, unl_r, comma_r;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
         txc_d_r <= 1'b0;
         rxc_d_r <= 1'b0;
      end else begin
         pin_s1_r <= {tx_parallel_clock, rx_parallel_clock_i, rx_pll_locked,
                      signal_detect, operating_mode_select, tx_word};
         pin_s2_r <= pin_s1_r;
         txc_d_r <= txc_s;
         rxc_d_r <= rxc_s;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tx_code_r <= '0;
         tx_valid_r <= 1'b0;
      end else begin
         tx_valid_r <= tx_edge; // R19
         if (tx_edge) tx_code_r <= tx_code_nxt; // R19
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prev_r <= '0;
         off_r <= '0;
      end else if (rx_group_valid) begin
         prev_r <= rx_code_group;
         if (comma_align_enable && |hit) off_r <= first_off; // R17
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_pend_r <= '0;
         rx_word_r <= '0;
         rx_clk_o_r <= 1'b0;
      end else begin
         if (rx_group_valid) rx_pend_r <= rx_word_nxt;
         // A shown violation is not shown again on the next edge
         else if (rx_upd && word_mode_8b) rx_pend_r[scd_pkg::RX_LCV_BIT] <= 1'b0; // R9
         if (rx_upd) rx_word_r <= rx_src; // R12
         if (rx_group_valid && !read_mode) rx_clk_o_r <= ~rx_clk_o_r; // R11
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         los_r <= 1'b0;
         unl_r <= 1'b1;
         comma_r <= 1'b0;
      end else begin
         los_r <= word_mode_8b & ~sig_s; // R15
         unl_r <= ~lock_s; // R16
         comma_r <= lock_s & (comma_r | (rx_group_valid & |hit)); // R17
      end
   end

   assign tx_code_group = tx_code_r;
   assign tx_group_valid = tx_valid_r;
   assign rx_parallel_word = rx_word_r;
   assign rx_parallel_clock_o = rx_clk_o_r;
   assign rx_parallel_clock_oe_n = read_mode; // R11 R12
   // Gated pass-through; the source comes from the on-chip PLL
   assign system_clock_out = system_clock_src & ~opm_s; // R14
   assign loss_of_signal = los_r;
   assign rx_pll_unlocked_n = unl_r;
   assign comma_found = comma_r;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence s_tx_raw;
      tx_edge && !word_mode_8b;
   endsequence
   sequence s_tx_enc;
      tx_edge && word_mode_8b;
   endsequence
   sequence s_rx_wr;
      rx_group_valid && !read_mode;
   endsequence

   a_tx_raw_pass: assert property (s_tx_raw |=> tx_group_valid
      && tx_code_group == $past(txw_s)) else $error("raw tx word mismatch"); // R1 R4
   a_tx_enc_path: assert property (s_tx_enc |=> tx_group_valid
      && tx_code_group == $past(cif.tx_code)) else $error("encoded tx mismatch"); // R2 R3
   a_tx_one_shot: assert property (tx_group_valid |=> !tx_group_valid)
      else $error("tx sampled twice"); // R19
   a_rx_raw_out: assert property (s_rx_wr and !word_mode_8b |=> rx_parallel_word
      == $past(grp)) else $error("raw rx word mismatch"); // R6
   a_rx_dec_out: assert property (s_rx_wr and word_mode_8b |=>
      rx_parallel_word[scd_pkg::RX_K_BIT:0] == $past({cif.rx_k, cif.rx_byte}))
      else $error("decoded rx mismatch"); // R7 R8
   a_lcv_single: assert property (read_mode && word_mode_8b && rx_upd && !rx_group_valid
      |=> !rx_pend_r[scd_pkg::RX_LCV_BIT]) else $error("violation repeated"); // R9
   a_rx_clk_drive: assert property (s_rx_wr |=> !rx_parallel_clock_oe_n
      && rx_parallel_clock_o != $past(rx_parallel_clock_o))
      else $error("recovered clock not toggled"); // R11
   a_rx_read_edge: assert property (read_mode && rx_edge |=> rx_parallel_word
      == $past(rx_pend_r) && rx_parallel_clock_oe_n) else $error("read edge miss"); // R12
   a_system_clock_out_gate: assert property (opm_s |-> !system_clock_out)
      else $error("system clock not gated"); // R14
   a_los_mode: assert property (!word_mode_8b ##1 !word_mode_8b |-> !loss_of_signal)
      else $error("loss flag in 10-bit mode"); // R15
   a_lock_status: assert property (lock_s |=> !rx_pll_unlocked_n)
      else $error("lock status wrong"); // R16
   a_comma_lock: assert property (comma_found |-> $past(lock_s))
      else $error("comma flag without lock"); // R17
endmodule : scd_port
`default_nettype wire

/* testbench/scd_host_model.sv */
// Host framer model: transmit word source and read-mode receive clock
`timescale 1ns/1ns
`default_nettype none
module scd_host_model (
   input wire logic core_clk,
   input wire logic tx_group_valid,
   input wire logic [scd_pkg::WORD_W-1:0] tx_code_group,
   output logic tx_parallel_clock,
   output logic [scd_pkg::WORD_W-1:0] tx_word,
   output logic rx_parallel_clock_i
);
   initial begin
      tx_parallel_clock = 1'b0;
      tx_word = '0;
      rx_parallel_clock_i = 1'b0;
   end
   // Clock high 160 ns per word, then low until the next word
   task automatic send(input logic [scd_pkg::WORD_W-1:0] w,
                       output logic [scd_pkg::WORD_W-1:0] got, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      got = '0;
      @(posedge core_clk);
      tx_word <= w;
      repeat (4) @(posedge core_clk);
      tx_parallel_clock <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         if (i == 3) tx_parallel_clock <= 1'b0;
         #1;
         if (tx_group_valid === 1'b1) begin
            n++;
            got = tx_code_group;
         end
      end
      // Exactly one pulse per clock period
      ok = (n == 1);
   endtask : send
   // Edges well apart so the core sees each one
   task automatic rx_edge();
      @(posedge core_clk);
      rx_parallel_clock_i <= ~rx_parallel_clock_i;
      repeat (4) @(posedge core_clk);
      #1;
   endtask : rx_edge
endmodule : scd_host_model
`default_nettype wire

/* testbench/scd_port_tb_top.sv */
// Self-checking bench for the parallel codec port
`timescale 1ns/1ns
`default_nettype none
module scd_port_tb_top;
   localparam int W = scd_pkg::WORD_W;
   logic core_clk, rst, word_mode_8b, rx_clock_read_mode, comma_align_enable;
   logic operating_mode_select, rx_group_valid, system_clock_src, signal_detect, rx_pll_locked;
   logic tx_parallel_clock, tx_group_valid, rx_parallel_clock_i, rx_parallel_clock_o;
   logic rx_parallel_clock_oe_n, system_clock_out, loss_of_signal, rx_pll_unlocked_n;
   logic comma_found, ok, clk_was;
   logic [W-1:0] tx_word, tx_code_group, rx_code_group, rx_parallel_word, got;
   int fails = 0;
   int n_compared = 0;
   logic [W-1:0] tx_in [4] = '{10'h0BC, 10'h1BC, 10'h0B5, 10'h1BC};
   logic [W-1:0] tx_exp [4] = '{10'h0EA, 10'h0FA, 10'h2AA, 10'h305};
   logic [W-1:0] rx_in [6] = '{10'h0FA, 10'h2AA, 10'h305, 10'h000, 10'h2AA, 10'h2AA};
   logic [W-1:0] rx_exp [6] = '{10'h04A, 10'h1BC, 10'h0B5, 10'h1BC, 10'h200, 10'h0B5};

   scd_port scd_port_inst (.core_clk(core_clk), .rst(rst), .word_mode_8b(word_mode_8b),
      .rx_clock_read_mode(rx_clock_read_mode), .comma_align_enable(comma_align_enable),
      .operating_mode_select(operating_mode_select), .tx_parallel_clock(tx_parallel_clock),
      .tx_word(tx_word), .tx_code_group(tx_code_group), .tx_group_valid(tx_group_valid),
      .rx_code_group(rx_code_group), .rx_group_valid(rx_group_valid),
      .rx_parallel_clock_i(rx_parallel_clock_i), .rx_parallel_clock_o(rx_parallel_clock_o),
      .rx_parallel_clock_oe_n(rx_parallel_clock_oe_n), .rx_parallel_word(rx_parallel_word),
      .system_clock_src(system_clock_src), .system_clock_out(system_clock_out),
      .signal_detect(signal_detect), .loss_of_signal(loss_of_signal),
      .rx_pll_locked(rx_pll_locked), .rx_pll_unlocked_n(rx_pll_unlocked_n),
      .comma_found(comma_found));

   scd_host_model scd_host_model_inst (.core_clk(core_clk), .tx_group_valid(tx_group_valid),
      .tx_code_group(tx_code_group), .tx_parallel_clock(tx_parallel_clock),
      .tx_word(tx_word), .rx_parallel_clock_i(rx_parallel_clock_i));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic check(input string name, input logic [W-1:0] exp, input logic [W-1:0] seen);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step

   // Deserializer side: data lines scrambled once the group is taken
   task automatic rx_group(input logic [W-1:0] g);
      @(posedge core_clk);
      rx_code_group <= g;
      rx_group_valid <= 1'b1;
      @(posedge core_clk);
      rx_group_valid <= 1'b0;
      rx_code_group <= ~g;
      #1;
   endtask : rx_group

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   initial begin
      rst = 1'b1;
      word_mode_8b = 1'b1;
      rx_clock_read_mode = 1'b0;
      comma_align_enable = 1'b0;
      operating_mode_select = 1'b0;
      rx_group_valid = 1'b0;
      rx_code_group = '0;
      system_clock_src = 1'b1;
      signal_detect = 1'b1;
      rx_pll_locked = 1'b0;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      step(4);
      check("unlocked_n", 10'h001, {9'h0, rx_pll_unlocked_n});
      check("clock pin oe_n", 10'h000, {9'h0, rx_parallel_clock_oe_n});
      check("loss of signal", 10'h000, {9'h0, loss_of_signal});
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         scd_host_model_inst.send(tx_in[i], got, ok);
         check("tx valid", 10'h001, {9'h0, ok});
         check("tx 8b group", tx_exp[i], got);
      end
      @(posedge core_clk);
      word_mode_8b <= 1'b0;
      scd_host_model_inst.send(10'h3A5, got, ok);
      check("tx raw group", 10'h3A5, got);
      $display("test transmit done");
      rx_group(10'h2A5);
      clk_was = rx_parallel_clock_o;
      rx_group(10'h155);
      check("rx raw word", 10'h2A5, rx_parallel_word);
      check("recovered clock", {9'h0, ~clk_was}, {9'h0, rx_parallel_clock_o});
      @(posedge core_clk);
      word_mode_8b <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rx_group(rx_in[i]);
         if (i == 4)
            check("violation bit", 10'h001, {9'h0, rx_parallel_word[9]});
         else
            check("rx 8b word", rx_exp[i], rx_parallel_word);
      end
      $display("test receive done");
      @(posedge core_clk);
      rx_pll_locked <= 1'b1;
      step(4);
      check("unlocked_n", 10'h000, {9'h0, rx_pll_unlocked_n});
      check("comma early", 10'h000, {9'h0, comma_found});
      // Comma is searched once its group is the older half of the window
      rx_group(10'h0FA);
      rx_group(10'h0FA);
      check("comma found", 10'h001, {9'h0, comma_found});
      @(posedge core_clk);
      rx_pll_locked <= 1'b0;
      step(4);
      check("comma cleared", 10'h000, {9'h0, comma_found});
      $display("test comma done");
      @(posedge core_clk);
      word_mode_8b <= 1'b0;
      rx_clock_read_mode <= 1'b1;
      rx_group(10'h2A5);
      check("clock pin oe_n", 10'h001, {9'h0, rx_parallel_clock_oe_n});
      scd_host_model_inst.rx_edge();
      check("read rise word", 10'h0FA, rx_parallel_word);
      rx_group(10'h155);
      check("read hold word", 10'h0FA, rx_parallel_word);
      scd_host_model_inst.rx_edge();
      check("read fall word", 10'h2A5, rx_parallel_word);
      @(posedge core_clk);
      word_mode_8b <= 1'b1;
      rx_group(10'h000);
      rx_group(10'h2AA);
      scd_host_model_inst.rx_edge();
      check("read violation", 10'h001, {9'h0, rx_parallel_word[9]});
      scd_host_model_inst.rx_edge();
      check("read violation once", 10'h000, {9'h0, rx_parallel_word[9]});
      $display("test read mode done");
      @(posedge core_clk);
      word_mode_8b <= 1'b0;
      rx_clock_read_mode <= 1'b0;
      comma_align_enable <= 1'b1;
      rx_group(10'h29F);
      rx_group(10'h2AA);
      check("aligned word", 10'h0FD, rx_parallel_word);
      rx_group(10'h155);
      check("alignment held", 10'h152, rx_parallel_word);
      $display("test align done");
      @(posedge core_clk);
      operating_mode_select <= 1'b1;
      signal_detect <= 1'b0;
      word_mode_8b <= 1'b1;
      step(4);
      check("system_clock_out gated", 10'h000, {9'h0, system_clock_out});
      check("loss 8b", 10'h001, {9'h0, loss_of_signal});
      @(posedge core_clk);
      operating_mode_select <= 1'b0;
      word_mode_8b <= 1'b0;
      step(4);
      check("system_clock_out running", 10'h001, {9'h0, system_clock_out});
      check("loss 10b", 10'h000, {9'h0, loss_of_signal});
      $display("test status done");
      wrap_up();
   end
endmodule : scd_port_tb_top
`default_nettype wire
